/* File: gpcd_regs.vh */
// Purpose: register map and constants of the port c / port d gpio block
// Assumes: avalon-mm word addressing, one 32-bit word per register
// Notes:   offsets are register indices; byte address is four times the index
// Operation
// - data writes reach the latch only with avs_byteenable bit 0 set
// - port c read: latch if output, pin if input
// - port d read: latch if output, pin if input
// - port c direction bit enables pin buffer
// - port d direction bit enables pin buffer
// - port c direction resets to inputs, always accessible
// - port d direction resets to inputs
// - data latches keep contents across reset
// - port c bit 0 always feeds second interrupt
// - pin 0 pullup on unless disable bit set
// - spi enable hands port c 2-5 to spi
// - infrared interface enable takes port c 6-7
// - keyboard enables make port d interrupt inputs
`ifndef GPCD_REGS_VH
`define GPCD_REGS_VH
`define GPCD_IDX_PORT_C_DATA 4'h2
`define GPCD_IDX_PORT_D_DATA 4'h3
`define GPCD_IDX_PORT_C_DIR  4'h4
`define GPCD_IDX_PORT_D_DIR  4'h5
`define GPCD_IDX_INT2_CTRL   4'hC
`define GPCD_PULLUP_DIS_BIT  6
`define GPCD_SECOND_EXTERNAL_INTERRUPT_BIT        0
`define GPCD_SPI_LO          2
`define GPCD_SPI_HI          5
`define GPCD_IR_TX_BIT       6
`define GPCD_IR_RX_BIT       7
`define GPCD_DIR_RESET       8'h00
`define GPCD_CTRL_RESET      8'h00
`endif

/* File: gpcd_port.v */
// Purpose: two 8-bit gpio ports with direction, read-back mux and pin sharing
// Assumes: pins synchronous to clk; peripheral enables come from their own blocks
// Notes:   answers every access in the cycle after it is presented
//          a write lands at the edge that sees waitrequest low
//          read data stand only while waitrequest is low
//          peripheral overrides reach the pin buffers, never the registers
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "gpcd_regs.vh"
module gpcd_port (
    input  wire        clk,                 // system clock, 125 MHz
    input  wire        nrst,                // synchronous reset, active low
    input  wire [3:0]  avs_address,         // word address
    input  wire        avs_read,            // read request
    input  wire        avs_write,           // write request
    input  wire [31:0] avs_writedata,       // write data
    input  wire [3:0]  avs_byteenable,      // byte enables
    output reg  [31:0] avs_readdata,        // read data
    output reg         avs_waitrequest,     // stall
    input  wire [7:0]  port_c_in,           // port c pin levels
    output reg  [7:0]  port_c_out,          // port c driven levels
    output reg  [7:0]  port_c_oe,           // port c output enables
    input  wire [7:0]  port_d_in,           // port d pin levels
    output reg  [7:0]  port_d_out,          // port d driven levels
    output reg  [7:0]  port_d_oe,           // port d output enables
    input  wire        spi_enable_bit,      // spi owns port c 5:2
    input  wire [3:0]  spi_pin_out,         // spi levels for port c 5:2
    input  wire [3:0]  spi_pin_oe,          // spi enables for port c 5:2
    output reg  [3:0]  spi_pin_in,          // port c 5:2 to spi
    input  wire        serial_if_enable,    // infrared interface owns port c 7:6
    input  wire        infrared_serial_transmit, // transmit level for port c 6
    output reg         infrared_serial_receive,  // port c 7 to receiver
    output reg         second_external_interrupt, // port c 0 level to second_external_interrupt
    output reg         pin0_pullup_en,      // pullup on port c 0
    input  wire [7:0]  keyboard_interrupt_enables, // keyboard enables
    output reg  [7:0]  keyboard_interrupt_inputs   // gated port d levels
);
////////////////////////////////////////////////////////////////////////////////
reg [7:0] port_c_data_reg;
reg [7:0] port_d_data_reg;
reg [7:0] port_c_direction_reg;
reg [7:0] port_d_direction_reg;
reg [7:0] int2_ctrl_reg;

// bus handshake: one-hot states, waitrequest low for one answer cycle
localparam [1:0] ST_IDLE    = 2'b01;
localparam [1:0] ST_ANSWER  = 2'b10;
localparam       SEL_C_DATA = 0;
localparam       SEL_D_DATA = 1;
localparam       SEL_C_DIR  = 2;
localparam       SEL_D_DIR  = 3;
localparam       SEL_CTRL   = 4;
localparam       SEL_NONE   = 5;

reg  [1:0] bus_state_reg;
reg  [1:0] bus_state_next;
reg  [7:0] rdata_next;

// one select bit per register, shared by write and read paths
function [5:0] decode_index;
    input [3:0] index;
    begin
        case (index)
        `GPCD_IDX_PORT_C_DATA: decode_index = 6'h01;
        `GPCD_IDX_PORT_D_DATA: decode_index = 6'h02;
        `GPCD_IDX_PORT_C_DIR:  decode_index = 6'h04;
        `GPCD_IDX_PORT_D_DIR:  decode_index = 6'h08;
        `GPCD_IDX_INT2_CTRL:   decode_index = 6'h10;
        default:               decode_index = 6'h20;
        endcase
    end
endfunction

wire [5:0] reg_sel   = decode_index(avs_address);
wire       bus_req   = avs_read | avs_write;
wire       in_idle   = (bus_state_reg == ST_IDLE);
wire       in_answer = (bus_state_reg == ST_ANSWER);
// a write lands only at the edge that sees waitrequest low
wire       wr        = avs_write & in_answer & avs_byteenable[0];
wire       rd_take   = avs_read & in_idle;

function [7:0] read_mux;
    input [7:0] latch;
    input [7:0] dir;
    input [7:0] pins;
    begin
        read_mux = (latch & dir) | (pins & ~dir);
    end
endfunction
////////////////////////////////////////////////////////////////////////////////
// latches have no reset: their contents survive it
always @(posedge clk)
begin
    if (wr && reg_sel[SEL_C_DATA])
    begin
        port_c_data_reg <= avs_writedata[7:0];
    end
    if (wr && reg_sel[SEL_D_DATA])
    begin
        port_d_data_reg <= avs_writedata[7:0];
    end
end

// next-state logic of the handshake
// an access always passes through exactly one answer cycle
always @*
begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
    ST_IDLE:
    begin
        if (bus_req)
            bus_state_next = ST_ANSWER;
    end
    ST_ANSWER:
    begin
        bus_state_next = ST_IDLE;
    end
    default:
    begin
        bus_state_next = ST_IDLE;
    end
    endcase
end

// read-back value of the selected register
// data pins read live, so an input pin is seen as it stands
always @*
begin
    rdata_next = 8'h00;
    if (reg_sel[SEL_C_DATA])
    begin
        rdata_next = read_mux(port_c_data_reg, port_c_direction_reg, port_c_in);
    end
    if (reg_sel[SEL_D_DATA])
    begin
        rdata_next = read_mux(port_d_data_reg, port_d_direction_reg, port_d_in);
    end
    if (reg_sel[SEL_C_DIR])
    begin
        rdata_next = port_c_direction_reg;
    end
    if (reg_sel[SEL_D_DIR])
    begin
        rdata_next = port_d_direction_reg;
    end
    if (reg_sel[SEL_CTRL])
    begin
        rdata_next = int2_ctrl_reg;
    end
    if (reg_sel[SEL_NONE])
    begin
        rdata_next = 8'h00;
    end
end

always @(posedge clk)
begin
    if (!nrst)
    begin
        bus_state_reg        <= ST_IDLE;
        port_c_direction_reg <= `GPCD_DIR_RESET;
        port_d_direction_reg <= `GPCD_DIR_RESET;
        int2_ctrl_reg        <= `GPCD_CTRL_RESET;
        avs_waitrequest      <= 1'b1;
        avs_readdata         <= 32'h0000_0000;
    end
    else
    begin
        bus_state_reg   <= bus_state_next;
        avs_waitrequest <= (bus_state_next != ST_ANSWER);
        if (wr && reg_sel[SEL_C_DIR])
        begin
            port_c_direction_reg <= avs_writedata[7:0];
        end
        if (wr && reg_sel[SEL_D_DIR])
        begin
            port_d_direction_reg <= avs_writedata[7:0];
        end
        if (wr && reg_sel[SEL_CTRL])
        begin
            int2_ctrl_reg <= {1'b0, avs_writedata[`GPCD_PULLUP_DIS_BIT], 6'h00};
        end
        // read data stand only in the answer cycle
        avs_readdata <= 32'h0000_0000;
        if (rd_take)
        begin
            avs_readdata <= {24'h00_0000, rdata_next};
        end
    end
end
////////////////////////////////////////////////////////////////////////////////
// pin muxing; peripherals override buffer only, never the registers
wire [7:0] c_out_next;
wire [7:0] c_oe_next;
wire [7:0] d_out_next;
wire [7:0] d_oe_next;
wire [7:0] kbd_next;
genvar     bit_i;

generate
    for (bit_i = 0; bit_i < 8; bit_i = bit_i + 1)
    begin : g_port_c_pin
        if (bit_i >= `GPCD_SPI_LO && bit_i <= `GPCD_SPI_HI)
        begin : g_spi
            // while spi_enable_bit is set, spi pins follow the spi block, not the port registers
            assign c_out_next[bit_i] = spi_enable_bit ? spi_pin_out[bit_i - `GPCD_SPI_LO]
                                                      : port_c_data_reg[bit_i];
            assign c_oe_next[bit_i]  = spi_enable_bit ? spi_pin_oe[bit_i - `GPCD_SPI_LO]
                                                      : port_c_direction_reg[bit_i];
        end
        else if (bit_i == `GPCD_IR_TX_BIT)
        begin : g_ir_tx
            assign c_out_next[bit_i] = serial_if_enable ? infrared_serial_transmit
                                                        : port_c_data_reg[bit_i];
            assign c_oe_next[bit_i]  = serial_if_enable | port_c_direction_reg[bit_i];
        end
        else if (bit_i == `GPCD_IR_RX_BIT)
        begin : g_ir_rx
            // receive pin is released while the interface owns it
            assign c_out_next[bit_i] = ~serial_if_enable & port_c_data_reg[bit_i];
            assign c_oe_next[bit_i]  = ~serial_if_enable & port_c_direction_reg[bit_i];
        end
        else
        begin : g_plain
            assign c_out_next[bit_i] = port_c_data_reg[bit_i];
            assign c_oe_next[bit_i]  = port_c_direction_reg[bit_i];
        end
    end
endgenerate

generate
    for (bit_i = 0; bit_i < 8; bit_i = bit_i + 1)
    begin : g_port_d_pin
        assign d_out_next[bit_i] = port_d_data_reg[bit_i];
        assign d_oe_next[bit_i]  = port_d_direction_reg[bit_i];
        // each enable bit turns its pin into a keyboard input
        assign kbd_next[bit_i] = keyboard_interrupt_enables[bit_i] & port_d_in[bit_i];
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// pin buffers: registered so every pin output comes from a flip-flop
always @(posedge clk)
begin
    if (!nrst)
    begin
        port_c_out <= 8'h00;
        port_c_oe  <= 8'h00;
    end
    else
    begin
        port_c_out <= c_out_next;
        port_c_oe  <= c_oe_next;
    end
end

always @(posedge clk)
begin
    if (!nrst)
    begin
        port_d_out <= 8'h00;
        port_d_oe  <= 8'h00;
    end
    else
    begin
        port_d_out <= d_out_next;
        port_d_oe  <= d_oe_next;
    end
end
////////////////////////////////////////////////////////////////////////////////
// levels handed to the peripherals that share the pins
always @(posedge clk)
begin
    if (!nrst)
    begin
        spi_pin_in                <= 4'h0;
        infrared_serial_receive   <= 1'b1;
        keyboard_interrupt_inputs <= 8'h00;
    end
    else
    begin
        spi_pin_in                <= port_c_in[`GPCD_SPI_HI:`GPCD_SPI_LO];
        infrared_serial_receive   <= port_c_in[`GPCD_IR_RX_BIT];
        keyboard_interrupt_inputs <= kbd_next;
    end
end

// second interrupt input and its pullup; port c bit 0 feeds it in every mode
always @(posedge clk)
begin
    if (!nrst)
    begin
        second_external_interrupt <= 1'b1;
        pin0_pullup_en            <= 1'b1;
    end
    else
    begin
        second_external_interrupt <= port_c_in[`GPCD_SECOND_EXTERNAL_INTERRUPT_BIT];
        pin0_pullup_en            <= ~int2_ctrl_reg[`GPCD_PULLUP_DIS_BIT];
    end
end
endmodule // gpcd_port
`default_nettype wire

/* File: gpcd_port_properties.sv */
// Purpose: port timing checks for gpcd_port
// Assumes: one clock, synchronous active-low reset
// Notes: side outputs lag their pins by one cycle
`timescale 1ns/100ps
`default_nettype none
module gpcd_port_props (
    input wire logic        clk, nrst, avs_read, avs_write, avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic [7:0]  port_c_in, port_d_in, port_c_oe, port_d_oe,
    input wire logic [7:0]  keyboard_interrupt_enables, keyboard_interrupt_inputs,
    input wire logic [3:0]  spi_pin_in,
    input wire logic        second_external_interrupt, infrared_serial_receive, pin0_pullup_en
);
    logic up = 1'b0;
    always @(posedge clk) up <= nrst;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_second_external_interrupt_lag: assert property (up |-> second_external_interrupt == $past(port_c_in[0]))
        else $error("second_external_interrupt level wrong");
    a_rx_lag: assert property (up |-> infrared_serial_receive == $past(port_c_in[7]))
        else $error("receive level wrong");
    a_spi_in_lag: assert property (up |-> spi_pin_in == $past(port_c_in[5:2]))
        else $error("spi input wrong");
    a_kbd_gate: assert property (up |-> keyboard_interrupt_inputs
        == $past(port_d_in & keyboard_interrupt_enables)) else $error("keyboard wrong");
    a_reset_state: assert property (!up |-> port_d_oe == 8'h00 && port_c_oe[1:0] == 2'b00
        && pin0_pullup_en) else $error("reset state wrong");
    a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_answer_soon: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[0:3] !avs_waitrequest) else $error("no answer");
    a_idle_rdata: assert property (avs_waitrequest |-> avs_readdata == 32'h0000_0000)
        else $error("read data while idle");
    c_read: cover property (avs_read && !avs_waitrequest);
    c_write: cover property (avs_write && !avs_waitrequest);
    c_kbd: cover property (keyboard_interrupt_inputs != 8'h00);
endmodule // gpcd_port_props
bind gpcd_port gpcd_port_props i_gpcd_port_props (.*);
`default_nettype wire

/* File: gpcd_board.sv */
// Purpose: board side of one port
// Assumes: no contention; Notes: undriven pins show the outside level
`timescale 1ns/100ps
`default_nettype none
module gpcd_board (
    input wire logic [7:0] out, oe, ext, // driven level, enable, outside level
    output logic [7:0]     pin           // level seen at the pin
);
    assign pin = (oe & out) | (~oe & ext);
endmodule // gpcd_board
`default_nettype wire

/* File: gpcd_port_tb.sv */
// Purpose: self-checking bench for gpcd_port
// Assumes: 125 MHz clock; Notes: board models turn enables into pin levels
`timescale 1ns/100ps
`default_nettype none
module gpcd_port_tb;
    logic clk = 0, nrst = 0, avs_read = 0, avs_write = 0, spi_enable_bit = 0, avs_waitrequest;
    logic serial_if_enable = 0, infrared_serial_transmit = 0, second_external_interrupt;
    logic infrared_serial_receive, pin0_pullup_en;
    logic [3:0] avs_address = 0, avs_byteenable = 4'h1, spi_pin_out = 0, spi_pin_oe = 0, spi_pin_in;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic [7:0] port_c_out, port_c_oe, port_d_out, port_d_oe, port_c_in, port_d_in, rd;
    logic [7:0] c_ext = 8'h3c, d_ext = 8'hc3, keyboard_interrupt_enables = 0;
    logic [7:0] keyboard_interrupt_inputs;
    int failures = 0, comparisons = 0;
    always #4 clk = ~clk;
    gpcd_port i_gpcd_port (.*);
    gpcd_board i_board_c (.out(port_c_out), .oe(port_c_oe), .ext(c_ext), .pin(port_c_in));
    gpcd_board i_board_d (.out(port_d_out), .oe(port_d_oe), .ext(d_ext), .pin(port_d_in));
    task chk(input string s, input logic [7:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a; avs_writedata <= {24'h00_0000, d}; avs_write <= w; avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0 && ++n < 40);
        rd = avs_readdata[7:0];
        avs_write <= 0; avs_read <= 0;
        repeat (2) @(posedge clk);
        if (n >= 40) failures++;
    endtask
    task do_reset;
        nrst <= 0;
        repeat (20) @(posedge clk);
        nrst <= 1;
        repeat (2) @(posedge clk);
    endtask
    task t_reset;
        chk("c oe", 8'h00, port_c_oe);
        chk("d oe", 8'h00, port_d_oe);
        chk("pullup", 8'h01, {7'h00, pin0_pullup_en});
        bus(0, 4'h4, 0); chk("c dir", 8'h00, rd);
        bus(0, 4'h5, 0); chk("d dir", 8'h00, rd);
        $display("test reset done");
    endtask
    task t_port(input int p);
        logic [3:0] a;
        a = 4'h2 + p[3:0];
        bus(1, a, 8'ha5);
        bus(0, a, 0); chk("pin read", p ? d_ext : c_ext, rd);
        bus(1, a + 4'h2, 8'h0f);
        bus(0, a, 0); chk("mixed read", p ? 8'hc5 : 8'h35, rd);
        chk("oe", 8'h0f, p ? port_d_oe : port_c_oe);
        chk("out", 8'h05, (p ? port_d_out : port_c_out) & 8'h0f);
        do_reset;
        bus(1, a + 4'h2, 8'hff); bus(0, a, 0); chk("kept latch", 8'ha5, rd);
        $display("test port %0d done", p);
    endtask
    task t_share;
        spi_enable_bit <= 1; spi_pin_out <= 4'h1; spi_pin_oe <= 4'h5; c_ext <= 8'h81;
        serial_if_enable <= 1; infrared_serial_transmit <= 1; keyboard_interrupt_enables <= 8'h0f;
        bus(1, 4'h4, 8'hff); bus(0, 4'h4, 0); chk("c dir", 8'hff, rd);
        chk("c oe", 8'h57, port_c_oe);
        chk("c out", 8'h44, port_c_out & 8'h54);
        chk("side in", 8'h31, {2'b00, second_external_interrupt, infrared_serial_receive,
            spi_pin_in});
        chk("kbd", 8'h05, keyboard_interrupt_inputs);
        bus(1, 4'hc, 8'h40); bus(0, 4'hc, 0); chk("pu reg", 8'h40, rd);
        chk("pullup", 8'h00, {7'h00, pin0_pullup_en});
        bus(0, 4'h7, 0); chk("unmapped", 8'h00, rd);
        avs_byteenable <= 4'h0;
        bus(1, 4'h5, 8'h00);
        avs_byteenable <= 4'h1;
        bus(0, 4'h5, 0); chk("byte lane off", 8'hff, rd);
        $display("test share done");
    endtask
    task report_and_stop;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        do_reset;
        t_reset;
        t_port(0);
        t_port(1);
        t_share;
        report_and_stop;
    end
    initial
    begin
        #20000;
        failures++;
        report_and_stop;
    end
endmodule // gpcd_port_tb
`default_nettype wire
